// >>> inc/psc_pkg.sv
// Constants, field layout, timing and state codes of the special config block.
package psc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int CFG_W  = 16;
  localparam int LO_W   = 8;

  // Byte addresses on the register bus.
  localparam logic [ADDR_W-1:0] CFG_OFFSET  = 8'h10;
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 8'h14;

  // Field positions of the configuration word.
  localparam int BIT_LOOP_OUT   = 0;
  localparam int BIT_SLEEP      = 1;
  localparam int BIT_PREAMBLE   = 2;
  localparam int BIT_SM_RESET   = 3;
  localparam int BIT_LOW_POWER  = 4;
  localparam int BIT_COLL_LED   = 5;
  localparam int BIT_SPEED_LED  = 6;
  localparam int BIT_FORCE_LINK = 7;
  localparam int BIT_RMII       = 8;

  // Reset value of the low byte and bits that always read as one.
  localparam logic [LO_W-1:0]  CFG_LO_RST     = 8'h14;
  localparam logic [LO_W-1:0]  SM_RESET_MASK  = 8'h08;
  localparam logic [CFG_W-1:0] CFG_FIXED_ONES = 16'h0200;
  localparam logic             RMII_RST       = 1'b0;

  // Field positions of the status word.
  localparam int STAT_SLEEP  = 0;
  localparam int STAT_BUSY   = 1;
  localparam int STAT_LINK   = 2;
  localparam int STAT_DETECT = 3;
  localparam int STAT_STRAP  = 4;

  // Length of the internal state machine reset pulse.
  localparam int CLK_PERIOD_NS = 4;
  localparam int SMR_TIME_NS   = 40;
  localparam int SMR_CNT_W     = 4;
  localparam logic [SMR_CNT_W-1:0] SMR_CYCLES =
    SMR_CNT_W'((SMR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [SMR_CNT_W-1:0] SMR_CNT_ZERO = 4'h0;
  localparam logic [SMR_CNT_W-1:0] SMR_CNT_ONE  = 4'h1;

  typedef enum logic [1:0] {
    SMR_IDLE = 2'h1,
    SMR_RUN  = 2'h2
  } psc_smr_state_t;

endpackage

// >>> core/psc_smr.sv
// Sequencer that holds the internal state machine reset for a fixed time.
`timescale 1ns/1ps
module psc_smr
  import psc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy
);

  psc_smr_state_t         state_reg;
  logic [SMR_CNT_W-1:0]   cnt_reg;

  // timed reset pulse.
  // A new start while running restarts the count, so no request is lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SMR_IDLE;
      cnt_reg   <= SMR_CNT_ZERO;
    end else if (start) begin
      state_reg <= SMR_RUN;
      cnt_reg   <= SMR_CYCLES - SMR_CNT_ONE;
    end else begin
      unique case (state_reg)
        SMR_IDLE: begin
          cnt_reg <= SMR_CNT_ZERO;
        end
        SMR_RUN: begin
          if (cnt_reg == SMR_CNT_ZERO) begin
            state_reg <= SMR_IDLE;
          end else begin
            cnt_reg <= cnt_reg - SMR_CNT_ONE;
          end
        end
        default: begin
          state_reg <= SMR_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_reg == SMR_RUN);

  property p_smr_start;
    @(posedge clk) disable iff (rst)
    start |=> busy && cnt_reg == SMR_CYCLES - SMR_CNT_ONE;
  endproperty
  a_smr_start: assert property (p_smr_start)
    else $error("reset pulse did not start");

  property p_smr_end;
    @(posedge clk) disable iff (rst)
    $fell(busy) |-> $past(cnt_reg) == SMR_CNT_ZERO && !$past(start);
  endproperty
  a_smr_end: assert property (p_smr_end)
    else $error("reset pulse ended early");

endmodule

// >>> core/psc_top.sv
// Special configuration register with its steering of indicators and modes.
`timescale 1ns/1ps
module psc_top
  import psc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [BE_W-1:0]   avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              rmii_strap,
  input  wire logic              link_ok_100,
  input  wire logic              speed_is_100,
  input  wire logic              signal_detect,
  input  wire logic              full_duplex,
  input  wire logic              collision,
  output logic                   link_good_100,
  output logic                   speed_indicator_out,
  output logic                   duplex_indicator_out,
  output logic                   auto_low_power_enable,
  output logic                   state_machine_reset,
  output logic                   mgmt_preamble_suppress,
  output logic                   sleep_mode,
  output logic                   remote_loop_out,
  output logic                   rmii_enable
);

  logic              ack_reg;
  logic              ack_next;
  logic              req;
  logic              take;
  logic              wr_cfg;
  logic              we_lo;
  logic              we_hi;
  logic [LO_W-1:0]   cfg_lo_reg;
  logic              rmii_reg;
  logic              strap_done_reg;
  logic              smr_start;
  logic              smr_busy;
  logic              wake;
  logic [CFG_W-1:0]  cfg_rd;
  logic [DATA_W-1:0] stat_rd;
  logic [DATA_W-1:0] rd_next;
  logic [DATA_W-1:0] readdata_reg;
  logic              link_good_reg;
  logic              speed_ind_reg;
  logic              duplex_ind_reg;

  // One wait cycle on every access: the read word is formed in the first
  // cycle and stands in a flop when waitrequest drops.
  assign req             = avs_read | avs_write;
  assign ack_next        = req & ~ack_reg;
  assign avs_waitrequest = req & ~ack_reg;
  assign take            = req & ack_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  assign wr_cfg = take & avs_write & (avs_address == CFG_OFFSET);
  assign we_lo  = wr_cfg & avs_byteenable[0];
  assign we_hi  = wr_cfg & avs_byteenable[1];

  assign wake = we_lo & cfg_lo_reg[BIT_SLEEP] & ~avs_writedata[BIT_SLEEP];

  assign smr_start = (we_lo & avs_writedata[BIT_SM_RESET]) | wake;

  psc_smr u_smr (
    .clk   (clk),
    .rst   (rst),
    .start (smr_start),
    .busy  (smr_busy)
  );

  // config storage.
  // The reset bit is never stored; it reads back the sequencer's busy level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_lo_reg <= CFG_LO_RST;
    end else if (we_lo) begin
      cfg_lo_reg <= avs_writedata[LO_W-1:0] & ~SM_RESET_MASK;
    end
  end

  // strap capture.
  // The strap is caught by the first clock after reset release, never by
  // the asynchronous reset itself.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rmii_reg       <= RMII_RST;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      rmii_reg       <= rmii_strap;
      strap_done_reg <= 1'b1;
    end else if (we_hi) begin
      rmii_reg <= avs_writedata[BIT_RMII];
    end
  end

  assign cfg_rd = CFG_FIXED_ONES
                | {{(CFG_W-LO_W-1){1'b0}}, rmii_reg,
                   cfg_lo_reg | (smr_busy ? SM_RESET_MASK : '0)};

  always_comb begin
    stat_rd              = '0;
    stat_rd[STAT_SLEEP]  = cfg_lo_reg[BIT_SLEEP];
    stat_rd[STAT_BUSY]   = smr_busy;
    stat_rd[STAT_LINK]   = link_good_reg;
    stat_rd[STAT_DETECT] = signal_detect;
    stat_rd[STAT_STRAP]  = rmii_strap;
  end

  always_comb begin
    rd_next = '0;
    if (avs_address == CFG_OFFSET) begin
      rd_next = {{(DATA_W-CFG_W){1'b0}}, cfg_rd};
    end else if (avs_address == STAT_OFFSET) begin
      rd_next = stat_rd;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_reg <= '0;
    end else if (avs_read && !ack_reg) begin
      readdata_reg <= rd_next;
    end
  end

  assign avs_readdata = readdata_reg;

  // forced link.
  // While asleep every indicator is powered down and reads low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_good_reg <= 1'b0;
    end else begin
      link_good_reg <= ~cfg_lo_reg[BIT_SLEEP]
                     & (cfg_lo_reg[BIT_FORCE_LINK] | link_ok_100);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_ind_reg <= 1'b0;
    end else if (cfg_lo_reg[BIT_SLEEP]) begin
      speed_ind_reg <= 1'b0;
    end else if (cfg_lo_reg[BIT_SPEED_LED]) begin
      speed_ind_reg <= signal_detect;
    end else begin
      speed_ind_reg <= speed_is_100;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duplex_ind_reg <= 1'b0;
    end else if (cfg_lo_reg[BIT_SLEEP]) begin
      duplex_ind_reg <= 1'b0;
    end else if (cfg_lo_reg[BIT_COLL_LED]) begin
      duplex_ind_reg <= full_duplex | collision;
    end else begin
      duplex_ind_reg <= full_duplex;
    end
  end

  assign link_good_100        = link_good_reg;
  assign speed_indicator_out  = speed_ind_reg;
  assign duplex_indicator_out = duplex_ind_reg;

  assign auto_low_power_enable  = cfg_lo_reg[BIT_LOW_POWER];
  assign state_machine_reset    = smr_busy;
  assign mgmt_preamble_suppress = cfg_lo_reg[BIT_PREAMBLE];
  assign sleep_mode             = cfg_lo_reg[BIT_SLEEP];
  assign remote_loop_out        = cfg_lo_reg[BIT_LOOP_OUT];
  assign rmii_enable            = rmii_reg;

  sequence s_wait_then_take;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  sequence s_cfg_write;
    avs_write && avs_address == CFG_OFFSET && avs_byteenable[0]
      && !avs_waitrequest;
  endsequence

  property p_bus_answer;
    @(posedge clk) disable iff (rst)
    $rose(req) |-> s_wait_then_take;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus access not answered in two cycles");

  property p_read_back;
    @(posedge clk) disable iff (rst)
    avs_read && avs_address == CFG_OFFSET && !avs_waitrequest
      |-> avs_readdata[LO_W-1:0] ==
          ($past(cfg_lo_reg) | ($past(smr_busy) ? SM_RESET_MASK : '0));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("config read data wrong");

  property p_force_link;
    @(posedge clk) disable iff (rst)
    cfg_lo_reg[BIT_FORCE_LINK] && !cfg_lo_reg[BIT_SLEEP] |=> link_good_100;
  endproperty
  a_force_link: assert property (p_force_link)
    else $error("forced link not reported good");

  property p_speed_norm;
    @(posedge clk) disable iff (rst)
    !cfg_lo_reg[BIT_SPEED_LED] && !cfg_lo_reg[BIT_SLEEP]
      |=> speed_indicator_out == $past(speed_is_100);
  endproperty
  a_speed_norm: assert property (p_speed_norm)
    else $error("speed indicator does not follow speed");

  property p_speed_dbg;
    @(posedge clk) disable iff (rst)
    cfg_lo_reg[BIT_SPEED_LED] && !cfg_lo_reg[BIT_SLEEP]
      |=> speed_indicator_out == $past(signal_detect);
  endproperty
  a_speed_dbg: assert property (p_speed_dbg)
    else $error("speed indicator does not follow signal detect");

  property p_duplex;
    @(posedge clk) disable iff (rst)
    !cfg_lo_reg[BIT_SLEEP] |=> duplex_indicator_out ==
      ($past(full_duplex)
       | ($past(cfg_lo_reg[BIT_COLL_LED]) & $past(collision)));
  endproperty
  a_duplex: assert property (p_duplex)
    else $error("duplex indicator wrong");

  property p_low_power;
    @(posedge clk) disable iff (rst)
    s_cfg_write
      |=> auto_low_power_enable == $past(avs_writedata[BIT_LOW_POWER]);
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power enable not written");

  property p_sm_reset;
    @(posedge clk) disable iff (rst)
    s_cfg_write ##0 avs_writedata[BIT_SM_RESET]
      |=> state_machine_reset [*8];
  endproperty
  a_sm_reset: assert property (p_sm_reset)
    else $error("state machine reset not held");

  property p_preamble;
    @(posedge clk) disable iff (rst)
    s_cfg_write
      |=> mgmt_preamble_suppress == $past(avs_writedata[BIT_PREAMBLE]);
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble mode not written");

  property p_sleep;
    @(posedge clk) disable iff (rst)
    s_cfg_write ##0 avs_writedata[BIT_SLEEP]
      |=> sleep_mode ##1 (!link_good_100 && !speed_indicator_out);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not entered");

  property p_wake;
    @(posedge clk) disable iff (rst)
    $fell(sleep_mode) |-> state_machine_reset && $past(wake);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not reset state machines");

  property p_loop;
    @(posedge clk) disable iff (rst)
    s_cfg_write |=> remote_loop_out == $past(avs_writedata[BIT_LOOP_OUT]);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop-out not written");

  property p_strap;
    @(posedge clk) disable iff (rst)
    $rose(strap_done_reg) |-> rmii_enable == $past(rmii_strap);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not latched");

endmodule

// >>> sim/psc_mgmt_master.sv
// Station management master model that drives the register bus.
`timescale 1ns/1ps
module psc_mgmt_master
  import psc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cmd_go,
  input  wire logic              cmd_wr,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_data,
  input  wire logic [BE_W-1:0]   cmd_be,
  output logic                   done,
  output logic      [DATA_W-1:0] rdata,
  output logic      [ADDR_W-1:0] avs_address,
  output logic                   avs_read,
  output logic                   avs_write,
  output logic      [DATA_W-1:0] avs_writedata,
  output logic      [BE_W-1:0]   avs_byteenable,
  input  wire logic [DATA_W-1:0] avs_readdata,
  input  wire logic              avs_waitrequest
);
  logic busy;

  // byte-enabled access.
  // Released address and data lines are inverted so stale values are never mistaken.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy           <= 1'b0;
      done           <= 1'b0;
      rdata          <= 32'h0;
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
      avs_address    <= 8'h0;
      avs_writedata  <= 32'h0;
      avs_byteenable <= 4'h0;
    end else begin
      done <= 1'b0;
      if (!busy && cmd_go) begin
        busy           <= 1'b1;
        avs_read       <= !cmd_wr;
        avs_write      <= cmd_wr;
        avs_address    <= cmd_addr;
        avs_writedata  <= cmd_data;
        avs_byteenable <= cmd_be;
      end else if (busy && !avs_waitrequest) begin
        busy          <= 1'b0;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~avs_address;
        avs_writedata <= ~avs_writedata;
        rdata         <= avs_readdata;
        done          <= 1'b1;
      end
    end
  end
endmodule

// >>> sim/tb_psc_top.sv
// Self-checking testbench of the special configuration register.
`timescale 1ns/1ps
module tb_psc_top;
  import psc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, wr = 1'b0, done;
  logic [ADDR_W-1:0] a = 8'h0, avs_address;
  logic [DATA_W-1:0] d = 32'h0, rdata, avs_writedata, avs_readdata, rd_v;
  logic [BE_W-1:0] be = 4'h0, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest;
  logic strap = 1'b1, lok = 1'b0, s100 = 1'b1, sdet = 1'b0;
  logic fdx = 1'b0, col = 1'b1;
  logic lg, spd, dpx, alp, smr, mps, slp, rlo, rme;
  int n_fail = 0, tests_run = 0, cyc = 0;

  always #2 clk = ~clk;

  psc_mgmt_master mst_u (.clk(clk), .rst(rst), .cmd_go(go), .cmd_wr(wr),
    .cmd_addr(a), .cmd_data(d), .cmd_be(be), .done(done), .rdata(rdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  psc_top dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rmii_strap(strap), .link_ok_100(lok), .speed_is_100(s100),
    .signal_detect(sdet), .full_duplex(fdx), .collision(col),
    .link_good_100(lg), .speed_indicator_out(spd),
    .duplex_indicator_out(dpx), .auto_low_power_enable(alp),
    .state_machine_reset(smr), .mgmt_preamble_suppress(mps),
    .sleep_mode(slp), .remote_loop_out(rlo), .rmii_enable(rme));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One bus access; the model holds it until waitrequest drops.
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] dt, input logic [3:0] b);
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    a  <= ad;
    d  <= dt;
    be <= b;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 20 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(done, 1'b1);
    rd_v = rdata;
  endtask

  task automatic wcfg(input logic [7:0] lo);
    xfer(1'b1, CFG_OFFSET, {23'h0, 1'b1, lo}, 4'h3);
    @(posedge clk);
    #1;
  endtask

  task automatic rcfg(input logic [7:0] lo, input logic rm);
    xfer(1'b0, CFG_OFFSET, 32'h0, 4'hF);
    chk(rd_v, {22'h0, 1'b1, rm, lo});
  endtask

  task automatic t_reset();
    rcfg(8'h14, 1'b1);
    chk({alp, mps, slp, rlo, rme}, 5'h19);
    chk(smr, 1'b0);
    xfer(1'b0, 8'h20, 32'h0, 4'hF);
    chk(rd_v, 32'h0);
  endtask

  task automatic t_link();
    chk(lg, 1'b0);
    @(posedge clk);
    lok <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(lg, 1'b1);
    @(posedge clk);
    lok <= 1'b0;
    wcfg(8'h94);
    chk(lg, 1'b1);
    wcfg(8'h14);
    chk(lg, 1'b0);
  endtask

  task automatic t_ind();
    chk(spd, 1'b1);
    @(posedge clk);
    s100 <= 1'b0;
    fdx  <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(spd, 1'b0);
    chk(dpx, 1'b1);
    @(posedge clk);
    s100 <= 1'b1;
    fdx  <= 1'b0;
    wcfg(8'h54);
    chk(spd, 1'b0);
    @(posedge clk);
    sdet <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(spd, 1'b1);
    chk(dpx, 1'b0);
    wcfg(8'h34);
    chk(dpx, 1'b1);
    chk(spd, 1'b1);
  endtask

  task automatic t_smr();
    wcfg(8'h1C);
    chk(smr, 1'b1);
    rcfg(8'h1C, 1'b1);
    for (int i = 0; i < 30 && smr !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(smr, 1'b0);
    rcfg(8'h14, 1'b1);
  endtask

  task automatic t_sleep();
    wcfg(8'hF5);
    chk({alp, mps, rlo}, 3'h7);
    wcfg(8'hF7);
    chk({slp, lg, spd}, 3'h4);
    xfer(1'b0, STAT_OFFSET, 32'h0, 4'hF);
    chk(rd_v[STAT_SLEEP], 1'b1);
    wcfg(8'hF5);
    chk({slp, smr}, 2'h1);
    for (int i = 0; i < 30 && smr !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(smr, 1'b0);
    rcfg(8'hF5, 1'b1);
  endtask

  task automatic t_lanes();
    xfer(1'b1, CFG_OFFSET, 32'hFFFF_FE00, 4'h2);
    rcfg(8'hF5, 1'b0);
    chk(rme, 1'b0);
    wcfg(8'h10);
    chk({alp, mps, rlo}, 3'h4);
    wcfg(8'h01);
    chk({alp, mps, rlo}, 3'h1);
  endtask

  // A second reset with the strap low must bring back every reset value.
  task automatic t_rerst();
    @(posedge clk);
    strap <= 1'b0;
    rst   <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(rme, 1'b0);
    rcfg(8'h14, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_link();
    t_ind();
    t_smr();
    t_sleep();
    t_lanes();
    t_rerst();
    finish_test();
  end
endmodule
